// *** hw/sacv_core.v ***
// conversion sequencer and serial data output of the sampling converter
// assumes strobe and serial clock already synchronous to ref_clk; the analog
// comparator result arrives one bit per cycle on cmp_bit
`include "sacv_map.vh"
module sacv_core #(
  parameter RES_BITS = `SACV_RES_BITS,
  parameter FIFO_DEPTH = `SACV_FIFO_DEPTH
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // host pins
  input wire sample_strobe,
  input wire sclk,
  output reg data_out,
  output reg data_oe,
  // analog side
  input wire cmp_bit,
  output reg hold_mode,
  output reg powered_down,
  output reg aborted,
  // result stream
  output reg res_valid,
  input wire res_ready,
  output reg [RES_BITS-1:0] res_data,
  output reg fifo_stall
);
  localparam ST_SAMPLE = 3'h0;
  localparam ST_SAMPLE_STROBE = 3'h1;
  localparam ST_LSB = 3'h2;
  localparam ST_PDOWN = 3'h3;
  localparam ST_DONE = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg strobe_q;
  reg sclk_q;
  reg [4:0] cycle;
  reg [RES_BITS-1:0] sar;
  reg [RES_BITS-1:0] result;
  reg [3:0] lsb_idx;
  reg strobe_went_high;
  reg push;
  wire strobe_rise;
  wire strobe_fall;
  wire sclk_fall;
  wire f_in_ready;
  wire f_out_valid;
  wire [RES_BITS-1:0] f_out_data;

  assign strobe_rise = sample_strobe && !strobe_q;
  assign strobe_fall = !sample_strobe && strobe_q;
  assign sclk_fall = !sclk && sclk_q;

  // next-state decisions; strobe edges take priority over clock edges
  always @* begin
    next_state = state;
    case (state)
      ST_SAMPLE: begin
        if (strobe_fall && f_in_ready) begin
          next_state = ST_SAMPLE_STROBE;
        end
      end
      ST_SAMPLE_STROBE: begin
        if (strobe_fall && strobe_went_high && cycle < `SACV_PD_CYCLE) begin
          next_state = ST_SAMPLE;
        end else if (strobe_fall && strobe_went_high) begin
          next_state = ST_LSB;
        end else if (sclk_fall && cycle == `SACV_PD_CYCLE - 1) begin
          next_state = strobe_went_high ? ST_DONE : ST_PDOWN;
        end
      end
      ST_LSB: begin
        if (strobe_rise) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_PDOWN: begin
        if (strobe_rise) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_DONE: begin
        if (strobe_fall) begin
          next_state = ST_LSB;
        end else if (sclk_fall) begin
          next_state = ST_SAMPLE;
        end
      end
      default: begin
        next_state = ST_SAMPLE;
      end
    endcase
  end

  // sequencer registers and serial output
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_PDOWN;
      strobe_q <= 1'b0;
      sclk_q <= 1'b0;
      cycle <= 5'h00;
      sar <= {RES_BITS{1'b0}};
      result <= {RES_BITS{1'b0}};
      lsb_idx <= 4'h0;
      strobe_went_high <= 1'b0;
      push <= 1'b0;
      data_out <= 1'b0;
      data_oe <= 1'b0;
      hold_mode <= 1'b0;
      powered_down <= 1'b1;
      aborted <= 1'b0;
    end else begin
      strobe_q <= sample_strobe;
      sclk_q <= sclk;
      state <= next_state;
      push <= 1'b0;
      aborted <= 1'b0;
      hold_mode <= (next_state == ST_SAMPLE_STROBE);
      // power-down state leaves sampling intact, so wake-up costs nothing
      powered_down <= (next_state == ST_PDOWN) || (next_state == ST_LSB);
      if (state == ST_SAMPLE && next_state == ST_SAMPLE_STROBE) begin
        cycle <= 5'h01;
        data_oe <= 1'b1;
        data_out <= 1'b0;
        sar <= {RES_BITS{1'b0}};
        strobe_went_high <= 1'b0;
      end else if (state == ST_SAMPLE_STROBE) begin
        if (sample_strobe) begin
          strobe_went_high <= 1'b1;
        end
        if (strobe_fall && strobe_went_high && cycle < `SACV_PD_CYCLE) begin
          data_oe <= 1'b0;
          aborted <= 1'b1;
        end else if (strobe_fall && strobe_went_high) begin
          // the lsb stays on the line until the next clock fall
          lsb_idx <= 4'h1;
        end else if (sclk_fall) begin
          cycle <= cycle + 5'h01;
          // cycles 1..12 decide and present one bit each, msb first
          if (cycle >= 5'h01 && cycle <= `SACV_LAST_BIT_CYCLE) begin
            sar[RES_BITS[3:0] - cycle[3:0]] <= cmp_bit;
            data_out <= cmp_bit;
          end
          if (cycle == `SACV_PD_CYCLE - 1) begin
            result <= {sar[RES_BITS-1:1], cmp_bit};
            push <= 1'b1;
            if (!strobe_went_high) begin
              data_oe <= 1'b0;
            end
          end
        end
      end else if (state == ST_DONE) begin
        if (strobe_fall) begin
          // bit 0 keeps standing for the rest of clock 13; resend starts on the next fall
          lsb_idx <= 4'h1;
        end else if (sclk_fall) begin
          data_oe <= 1'b0;
        end
      end else if (state == ST_LSB) begin
        if (strobe_rise) begin
          data_oe <= 1'b0;
        end else if (sclk_fall) begin
          // eleven more bits, least significant first
          if (lsb_idx < RES_BITS[3:0]) begin
            data_out <= result[lsb_idx];
            lsb_idx <= lsb_idx + 4'h1;
          end else begin
            data_oe <= 1'b0;
          end
        end
      end else if (state == ST_PDOWN && strobe_rise) begin
        data_oe <= 1'b0;
      end
    end
  end

  // result stream output register; the fifo refuses starts when full
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res_data <= {RES_BITS{1'b0}};
      fifo_stall <= 1'b0;
    end else begin
      fifo_stall <= !f_in_ready;
      if (!res_valid || res_ready) begin
        res_valid <= f_out_valid;
        res_data <= f_out_data;
      end
    end
  end

  sacv_fifo #(
    .WIDTH(RES_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(result),
    .out_valid(f_out_valid),
    .out_ready(!res_valid || res_ready),
    .out_data(f_out_data)
  );
endmodule // sacv_core

// *** hw/sacv_fifo.v ***
// small synchronous fifo carrying finished conversion results
// assumes one clock and an asynchronous active-low reset
module sacv_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // write side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // read side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;

  // full and empty come straight from the occupancy count
  assign in_ready = (count != DEPTH);
  assign out_valid = (count != 0);
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // storage has no reset; only pointers and count need a defined value
  always @(posedge ref_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointer and count update; depth need not be a power of two
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sacv_fifo

// *** hw/sacv_map.vh ***
// constants for the sampling converter sequencing and serial output logic
// assumes one system clock at 200 MHz; strobe and serial clock sampled synchronously
`ifndef SACV_MAP_VH
`define SACV_MAP_VH

`define SACV_RES_BITS 12
`define SACV_FRAME_CLKS 16
`define SACV_PD_CYCLE 13
`define SACV_LSB_CYCLE 13
`define SACV_LAST_BIT_CYCLE 12
`define SACV_FIFO_DEPTH 8
`define SACV_CLK_PERIOD_PS 5000
`define SACV_ACQ_NS 350
`define SACV_ACQ_CYC ((`SACV_ACQ_NS * 1000 + `SACV_CLK_PERIOD_PS - 1) / `SACV_CLK_PERIOD_PS)
`define SACV_DROOP_US 5
`define SACV_DROOP_CYC ((`SACV_DROOP_US * 1000000) / `SACV_CLK_PERIOD_PS)

`endif

// *** testbench/sacv_core_props.sv ***
// assertion checker on the converter sequencer ports
// assumes one ref_clk domain; bound from the bench top file
module sacv_core_props (
  // clock and reset
  input logic ref_clk,
  input logic rst_n,
  // host pins and status
  input logic sample_strobe,
  input logic sclk,
  input logic data_out,
  input logic data_oe,
  input logic hold_mode,
  input logic powered_down,
  input logic aborted,
  input logic fifo_stall
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic sclk_q;
  logic [4:0] sample_strobe_cnt;
  wire fall = sclk_q & ~sclk;
  // falls counted in a register so long frames need no long repetition
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      sample_strobe_cnt <= 5'h00;
    end else begin
      sclk_q <= sclk;
      sample_strobe_cnt <= hold_mode ? sample_strobe_cnt + {4'h0, fall} : 5'h00;
    end
  end
  sequence s_start;
    $fell(sample_strobe) && !hold_mode && !data_oe && !powered_down && !fifo_stall;
  endsequence
  sequence s_drive_low;
    data_oe && !data_out && hold_mode;
  endsequence
  sequence s_last_fall_low;
    hold_mode && fall && sample_strobe_cnt == 5'h0B && !sample_strobe;
  endsequence
  property p_start; s_start |-> ##[1:2] s_drive_low; endproperty
  a_start: assert property (p_start) else $error("start not low");
  property p_pd_stay; powered_down && !sample_strobe |=> powered_down; endproperty
  a_pd_stay: assert property (p_pd_stay) else $error("left power-down");
  property p_wake; $rose(sample_strobe) && powered_down |-> ##[0:3] !powered_down; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_pd_entry; s_last_fall_low |-> ##[0:2] (powered_down && !data_oe); endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("no power-down");
  property p_sample_strobe_len; sample_strobe_cnt <= 5'h0C; endproperty
  a_sample_strobe_len: assert property (p_sample_strobe_len) else $error("frame too long");
  property p_pd_quiet; powered_down && !data_oe |=> !data_oe; endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("line driven in power-down");
  property p_abort; $fell(sample_strobe) && data_oe && hold_mode && sample_strobe_cnt < 5'h0C
    |-> ##[1:2] aborted; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_abort_hiz; aborted |-> ##[0:1] !data_oe ##1 !data_oe; endproperty
  a_abort_hiz: assert property (p_abort_hiz) else $error("line not released");
endmodule // sacv_core_props

// *** testbench/sacv_host.sv ***
// host model: strobe, serial clock and comparator decisions per frame
// assumes pins sampled on ref_clk rise; data line pulled up when released
module sacv_host (
  // clock
  input logic ref_clk,
  // host pins
  output logic sample_strobe,
  output logic sclk,
  input logic data_out,
  input logic data_oe,
  // comparator stand-in
  output logic cmp_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ACQ_CYC = 70; // 350 ns at 5 ns a cycle
  wire line = data_oe ? data_out : 1'b1; // pull-up, never the last value
  initial begin
    sample_strobe = 1'b0;
    sclk = 1'b0;
    cmp_bit = 1'b0;
  end
  // mode 0 plain, 1 short-cycle, 2 lsb-first, 3 plain expecting refusal,
  // 4 continuous: strobe rises in clock 10 and stays high past the frame
  task automatic frame(input logic [11:0] w, input int mode, output logic [10:0] cap);
    @(negedge ref_clk) sample_strobe = 1'b1;
    repeat (ACQ_CYC) @(negedge ref_clk);
    sample_strobe = 1'b0;
    @(negedge ref_clk);
    // clock stands low outside frames and runs fast inside them
    for (int k = 1; k <= ((mode == 2) ? 24 : 16); k++) begin
      if ((mode == 1 && k == 4) || ((mode == 2 || mode == 4) && k == 10)) sample_strobe = 1'b1;
      if ((mode == 1 && k == 7) || (mode == 2 && k == 13)) sample_strobe = 1'b0;
      sclk = 1'b1;
      cmp_bit = (k <= 12) ? w[12-k] : ~cmp_bit;
      @(negedge ref_clk);
      if (k >= 2 && k <= 12) cap[12-k] = line;
      if (mode == 2 && k >= 14) cap[k-14] = line;
      sclk = 1'b0;
      @(negedge ref_clk);
    end
  endtask
endmodule // sacv_host

// *** testbench/testbench.sv ***
// self-checking bench for the converter sequencer with a host model
// assumes the host model drives its pins at falling clock edges
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic res_ready = 1'b1;
  wire sample_strobe, sclk, cmp_bit, data_out, data_oe, hold_mode, powered_down;
  wire aborted, res_valid, fifo_stall;
  wire [11:0] res_data;
  logic [11:0] exp_q[$];
  logic [11:0] w;
  logic [10:0] cap;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  sacv_core uut (.ref_clk(ref_clk), .rst_n(rst_n), .sample_strobe(sample_strobe), .sclk(sclk),
    .data_out(data_out), .data_oe(data_oe), .cmp_bit(cmp_bit), .hold_mode(hold_mode),
    .powered_down(powered_down), .aborted(aborted), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data), .fifo_stall(fifo_stall));
  sacv_host hst (.ref_clk(ref_clk), .sample_strobe(sample_strobe), .sclk(sclk),
    .data_out(data_out), .data_oe(data_oe), .cmp_bit(cmp_bit));
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // oldest note taken whenever a word leaves; an empty queue pops unknown
  always @(posedge ref_clk) begin
    cyc++;
    if (res_valid === 1'b1 && res_ready === 1'b1) begin
      check(res_data === exp_q.pop_front(), "result word");
    end
    if (cyc == 3000) begin
      check(1'b0, "timeout");
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h71ff));
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    // all ones first, straight after the reset power-down
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 12'hFFF : 12'($urandom);
      exp_q.push_back(w);
      hst.frame(w, (i == 2) ? 4 : 0, cap);
      check(cap === w[11:1], "serial bits");
      check(powered_down === (i != 2) && data_oe === 1'b0, "frame end state");
    end
    $display("test plain frames done");
    hst.frame(12'h5A5, 1, cap);
    check(data_oe === 1'b0 && hold_mode === 1'b0 && powered_down === 1'b0, "short cycle");
    $display("test short cycle done");
    w = 12'($urandom);
    exp_q.push_back(w);
    hst.frame(w, 2, cap);
    check(cap === w[11:1], "lsb-first bits");
    check(powered_down === 1'b1 && data_oe === 1'b0, "lsb-first end");
    $display("test lsb first done");
    // consumer stalls; one word waits at the output, eight fill the fifo, a tenth is refused
    res_ready = 1'b0;
    for (int i = 0; i < 9; i++) begin
      w = 12'($urandom);
      exp_q.push_back(w);
      hst.frame(w, 0, cap);
    end
    check(fifo_stall === 1'b1, "fifo not full");
    hst.frame(12'h0F0, 3, cap);
    check(powered_down === 1'b0 && fifo_stall === 1'b1, "start not refused");
    res_ready = 1'b1;
    repeat (20) @(negedge ref_clk);
    check(exp_q.size() == 0 && fifo_stall === 1'b0, "fifo not drained");
    $display("test fifo done");
    end_of_test();
  end
endmodule // testbench

bind sacv_core sacv_core_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .sample_strobe(sample_strobe), .sclk(sclk), .data_out(data_out), .data_oe(data_oe),
  .hold_mode(hold_mode), .powered_down(powered_down), .aborted(aborted),
  .fifo_stall(fifo_stall));
